// ==== rtl/power_stage_fault_diag.v ====
// Purpose: Fault diagnosis and protection for 8 low-side and 4 ignition outputs
// Assumes: Comparator results and ignition pins are asynchronous levels
// Notes:   Registers over AXI4-Lite; a read of a diag register is a diagnosis read
//
// How it works
// - Each channel keeps its own two-bit status
// - Codes: 11 ok, 01 open, 10 battery, 00 ground
// - Low-side faults latch until read; read clears
// - Off: first fault kept; on-fault may overwrite
// - Overcurrent past filter switches off, codes 10
// - Overcurrent filter time is four microseconds
// - Rearm on command toggle or diag read
// - Off voltage classifies ground, open, or ok
// - Off diagnosis masked after switch-off
// - Mask interval is 400 microseconds
// - Off faults latch after persisting
// - Off-state filter time is 50 microseconds
// - Pull disable stops channel 7 off diagnosis
// - Ignition on needs serial bit and pin
// - Reset or output disable floats ignition outputs
// - Low-side disable keeps ignition low stage off
// - Ignition ground short by method, floats, latches
// - Ground-short float ends on read or toggle
// - Ignition open load latches, output still driven
// - Battery short in any state floats output
// - Battery short outranks open load in code
// - Latch mode: battery fault held until read
// - No-latch mode: clears after low voltage persists
`timescale 1ns/100ps
`include "power_stage_fault_diag_defs.vh"
`default_nettype none

// ----------------------------------------------------------------
// Persistence filter: hit while cond has held N cycles
// ----------------------------------------------------------------
module persist_filter #(
    parameter N = 2,
    parameter W = 16
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire cond_i,
    output wire hit_o
);
    localparam [31:0] LAST32 = N - 1;
    localparam [W-1:0] LAST = LAST32[W-1:0];
    reg [W-1:0] cnt_reg;

    always @(posedge ref_clk_i) begin
        if (!rst_n_i || !cond_i) begin
            cnt_reg <= {W{1'b0}};
        end else if (cnt_reg != LAST) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign hit_o = cond_i && (cnt_reg == LAST);
endmodule

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module power_stage_fault_diag #(
    parameter MASK_CYC = `OFF_MASK_CYC
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [7:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    input wire [7:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    input wire [7:0] ls_ovc_i,
    input wire [7:0] ls_below_low_i,
    input wire [7:0] ls_below_high_i,
    output reg [7:0] ls_drive_o,
    output reg lc_pull_en_o,
    input wire [3:0] ign_par_i,
    input wire [3:0] ign_ovc_i,
    input wire [3:0] ign_below_lvt_i,
    input wire [3:0] ign_open_i,
    input wire [3:0] ign_scb_i,
    output reg [3:0] ign_high_o,
    output reg [3:0] ign_oe_o
);
    localparam LC_CH = 7;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    reg [43:0] sync1_reg;
    reg [43:0] sync2_reg;
    wire [43:0] raw_in = {ign_scb_i, ign_open_i, ign_below_lvt_i, ign_ovc_i, ign_par_i,
                          ls_below_high_i, ls_below_low_i, ls_ovc_i};
    always @(posedge ref_clk_i) begin
        sync1_reg <= raw_in;
        sync2_reg <= sync1_reg;
    end
    wire [7:0] ls_ovc_s = sync2_reg[7:0];
    wire [7:0] ls_low_s = sync2_reg[15:8];
    wire [7:0] ls_high_s = sync2_reg[23:16];
    wire [3:0] ign_par_s = sync2_reg[27:24];
    wire [3:0] ign_ovc_s = sync2_reg[31:28];
    wire [3:0] ign_lvt_s = sync2_reg[35:32];
    wire [3:0] ign_open_s = sync2_reg[39:36];
    wire [3:0] ign_scb_s = sync2_reg[43:40];

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    reg [7:0] ls_cmd_reg;
    reg [3:0] ign_cmd_reg;
    reg [4:0] cfg_reg;
    reg [7:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    wire [15:0] ls_code;
    wire [7:0] ign_code;
    wire [3:0] ign_oe_next;

    wire aw_take = s_axi_awvalid_i && s_axi_awready_o;
    wire w_take = s_axi_wvalid_i && s_axi_wready_o;
    wire wr_go = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
    wire ar_take = s_axi_arvalid_i && s_axi_arready_o;
    wire diag_rd_ls = ar_take && (s_axi_araddr_i == `ADDR_DIAG_LS);
    wire diag_rd_ign = ar_take && (s_axi_araddr_i == `ADDR_DIAG_IGN);
    wire wr_hit = (awaddr_reg == `ADDR_LS_CMD) || (awaddr_reg == `ADDR_IGN_CMD) ||
                  (awaddr_reg == `ADDR_CONFIG_TWO);

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `RESP_OKAY;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            ls_cmd_reg <= `LS_CMD_RESET;
            ign_cmd_reg <= `IGN_CMD_RESET;
            cfg_reg <= `CONFIG_TWO_RESET;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr_i;
                s_axi_awready_o <= 1'b0;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata_i;
                wstrb_reg <= s_axi_wstrb_i;
                s_axi_wready_o <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
                if (wstrb_reg[0]) begin
                    case (awaddr_reg)
                        `ADDR_LS_CMD: ls_cmd_reg <= wdata_reg[7:0];
                        `ADDR_IGN_CMD: ign_cmd_reg <= wdata_reg[3:0];
                        `ADDR_CONFIG_TWO: cfg_reg <= wdata_reg[4:0];
                        default: ;
                    endcase
                end
            end
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // Read data is sampled from the codes before this cycle's clear
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= `RESP_OKAY;
            case (s_axi_araddr_i)
                `ADDR_LS_CMD: s_axi_rdata_o <= {24'h000000, ls_cmd_reg};
                `ADDR_IGN_CMD: s_axi_rdata_o <= {28'h0000000, ign_cmd_reg};
                `ADDR_CONFIG_TWO: s_axi_rdata_o <= {27'h0000000, cfg_reg};
                `ADDR_DIAG_LS: s_axi_rdata_o <= {16'h0000, ls_code};
                `ADDR_DIAG_IGN: s_axi_rdata_o <= {24'h000000, ign_code};
                `ADDR_STATUS: s_axi_rdata_o <= {20'h00000, ign_oe_o, ls_drive_o};
                default: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= `RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    wire ign_ls_dis = cfg_reg[`CFG_IGN_LS_DISABLE];
    wire output_disable_bit = cfg_reg[`CFG_OUTPUT_DISABLE];
    wire gnd_by_volt = cfg_reg[`CFG_GND_METHOD_SEL];
    wire ign_latch = cfg_reg[`CFG_IGN_LATCH_SEL];
    wire lc_pull_dis = cfg_reg[`CFG_LC_PULL_DISABLE];

    // ------------------------------------------------------------
    // Low-side channels
    // ------------------------------------------------------------
    wire [7:0] ls_drive_next;
    genvar i;
        for (i = 0; i < 8; i = i + 1) begin : g_ls
            reg [1:0] code_reg;
            reg cmd_prev_reg;
            reg ovc_off_reg;
            reg drive_reg;
            reg [15:0] mask_reg;
            reg [1:0] code_next;
            wire ovc_hit, gs_hit, ol_hit;
            wire cmd = ls_cmd_reg[i];
            wire rearm = (cmd && !cmd_prev_reg) || (diag_rd_ls && cmd);
            wire off_en = !drive_reg && (mask_reg == 16'h0000) &&
                          !((i == LC_CH) && lc_pull_dis);
            wire ovc_off_next = ovc_hit || (ovc_off_reg && !rearm);
            assign ls_drive_next[i] = cmd && !ovc_off_next;

            persist_filter #(.N(`OVC_FILT_CYC)) u_ovc (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
                .cond_i(drive_reg && ls_ovc_s[i]), .hit_o(ovc_hit));
            persist_filter #(.N(`OFF_FILT_CYC)) u_gs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
                .cond_i(off_en && ls_low_s[i]), .hit_o(gs_hit));
            persist_filter #(.N(`OFF_FILT_CYC)) u_ol (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
                .cond_i(off_en && !ls_low_s[i] && ls_high_s[i]), .hit_o(ol_hit));

            // Clear first, then this cycle's event, so a read never swallows a fault
            always @* begin
                code_next = diag_rd_ls ? `CODE_OK : code_reg;
                if (ovc_hit) begin
                    code_next = `CODE_BAT_SHORT;
                end else if (code_next == `CODE_OK && gs_hit) begin
                    code_next = `CODE_GND_SHORT;
                end else if (code_next == `CODE_OK && ol_hit) begin
                    code_next = `CODE_OPEN_LOAD;
                end
            end

            always @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    code_reg <= `CODE_OK;
                    cmd_prev_reg <= 1'b0;
                    ovc_off_reg <= 1'b0;
                    drive_reg <= 1'b0;
                    mask_reg <= 16'h0000;
                end else begin
                    code_reg <= code_next;
                    cmd_prev_reg <= cmd;
                    ovc_off_reg <= ovc_off_next;
                    drive_reg <= ls_drive_next[i];
                    if (drive_reg && !ls_drive_next[i]) begin
                        mask_reg <= MASK_CYC[15:0];
                    end else if (mask_reg != 16'h0000) begin
                        mask_reg <= mask_reg - 16'h0001;
                    end
                end
            end
            assign ls_code[2*i+1:2*i] = code_reg;
        end

    // ------------------------------------------------------------
    // Ignition pre-drivers
    // ------------------------------------------------------------
    wire [3:0] ign_on_next;
    genvar j;
        for (j = 0; j < 4; j = j + 1) begin : g_ign
            reg [1:0] code_reg;
            reg cmd_prev_reg;
            reg gs_hiz_reg;
            reg scb_hiz_reg;
            reg [1:0] code_next;
            wire gs_hit, ol_hit, scb_hit, clr_hit;
            wire cmd = ign_cmd_reg[j] && ign_par_s[j];
            wire rearm = (cmd && !cmd_prev_reg) || diag_rd_ign;
            wire on = cmd && !gs_hiz_reg && !scb_hiz_reg && !output_disable_bit;
            wire gs_cond = on && (gnd_by_volt ? ign_lvt_s[j] : ign_ovc_s[j]);
            wire gs_hiz_next = gs_hit || (gs_hiz_reg && !rearm);
            wire scb_hiz_next = scb_hit ||
                (scb_hiz_reg && !(ign_latch ? rearm : clr_hit));
            assign ign_on_next[j] = cmd && !gs_hiz_next && !scb_hiz_next && !output_disable_bit;
            // Low stage only drives the off level when not disabled
            assign ign_oe_next[j] = !output_disable_bit && !gs_hiz_next && !scb_hiz_next &&
                                    (ign_on_next[j] || !ign_ls_dis);

            persist_filter #(.N(`IGN_FILT_CYC)) u_gs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
                .cond_i(gs_cond), .hit_o(gs_hit));
            persist_filter #(.N(`IGN_FILT_CYC)) u_ol (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
                .cond_i(on && ign_open_s[j]), .hit_o(ol_hit));
            persist_filter #(.N(`IGN_FILT_CYC)) u_scb (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
                .cond_i(ign_scb_s[j] && !scb_hiz_reg), .hit_o(scb_hit));
            persist_filter #(.N(`IGN_FILT_CYC)) u_clr (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
                .cond_i(scb_hiz_reg && !ign_scb_s[j] && !ign_latch), .hit_o(clr_hit));

            always @* begin
                code_next = diag_rd_ign ? `CODE_OK : code_reg;
                if (!ign_latch && clr_hit && code_next == `CODE_BAT_SHORT) begin
                    code_next = `CODE_OK;
                end
                if (scb_hit) begin
                    code_next = `CODE_BAT_SHORT;
                end else if (gs_hit && code_next != `CODE_BAT_SHORT) begin
                    code_next = `CODE_GND_SHORT;
                end else if (ol_hit && code_next == `CODE_OK) begin
                    code_next = `CODE_OPEN_LOAD;
                end
            end

            always @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    code_reg <= `CODE_OK;
                    cmd_prev_reg <= 1'b0;
                    gs_hiz_reg <= 1'b0;
                    scb_hiz_reg <= 1'b0;
                end else begin
                    code_reg <= code_next;
                    cmd_prev_reg <= cmd;
                    gs_hiz_reg <= gs_hiz_next;
                    scb_hiz_reg <= scb_hiz_next;
                end
            end
            assign ign_code[2*j+1:2*j] = code_reg;
        end

    // ------------------------------------------------------------
    // Output flops
    // ------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            ls_drive_o <= 8'h00;
            lc_pull_en_o <= 1'b0;
            ign_high_o <= 4'h0;
            ign_oe_o <= 4'h0;
        end else begin
            ls_drive_o <= ls_drive_next;
            lc_pull_en_o <= !lc_pull_dis;
            ign_high_o <= ign_on_next;
            ign_oe_o <= ign_oe_next;
        end
    end
endmodule

`default_nettype wire

// ==== rtl/power_stage_fault_diag_defs.vh ====
// Purpose: Constants for the power stage fault diagnosis block
// Assumes: 40 MHz ref clock; AXI4-Lite byte addresses, one word per register
// Notes:   Times are given in ns and turned into clock counts here
`ifndef POWER_STAGE_FAULT_DIAG_DEFS_VH
`define POWER_STAGE_FAULT_DIAG_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define OVC_FILT_CYC ((4000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_MASK_CYC ((400000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OFF_FILT_CYC ((50000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IGN_FILT_CYC ((75000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Fault codes, two bits per channel
// ----------------------------------------------------------------
`define CODE_OK 2'b11
`define CODE_OPEN_LOAD 2'b01
`define CODE_BAT_SHORT 2'b10
`define CODE_GND_SHORT 2'b00

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_LS_CMD 8'h00
`define ADDR_IGN_CMD 8'h04
`define ADDR_CONFIG_TWO 8'h08
`define ADDR_DIAG_LS 8'h0c
`define ADDR_DIAG_IGN 8'h10
`define ADDR_STATUS 8'h14

`define CFG_IGN_LS_DISABLE 0
`define CFG_OUTPUT_DISABLE 1
`define CFG_GND_METHOD_SEL 2
`define CFG_IGN_LATCH_SEL 3
`define CFG_LC_PULL_DISABLE 4

`define LS_CMD_RESET 8'h00
`define IGN_CMD_RESET 4'h0
`define CONFIG_TWO_RESET 5'h08

`define RESP_OKAY 2'b00
`define RESP_DECERR 2'b11

`endif

// ==== verif/load_model.sv ====
// Purpose: Loads and ignition transistors seen by the comparators
// Assumes: Fault selects come from the bench
// Notes:   Comparator levels follow the drive state with no delay
`timescale 1ns/100ps
`default_nettype none
module load_model (
    input wire logic [7:0] ls_drive_i,
    input wire logic [7:0] ls_short_i,
    input wire logic [7:0] ls_gnd_i,
    input wire logic [7:0] ls_open_i,
    input wire logic [3:0] ign_high_i,
    input wire logic [3:0] ign_oe_i,
    input wire logic [3:0] ign_gnd_i,
    input wire logic [3:0] ign_open_i,
    input wire logic [3:0] ign_bat_i,
    output wire logic [7:0] ls_ovc_o,
    output wire logic [7:0] ls_below_low_o,
    output wire logic [7:0] ls_below_high_o,
    output wire logic [3:0] ign_ovc_o,
    output wire logic [3:0] ign_below_lvt_o,
    output wire logic [3:0] ign_open_o,
    output wire logic [3:0] ign_scb_o
);
    wire [3:0] src = ign_oe_i & ign_high_i;
    assign ls_ovc_o = ls_drive_i & ls_short_i;
    // A conducting switch pulls its pin under both thresholds
    assign ls_below_low_o = ls_drive_i | ls_gnd_i;
    assign ls_below_high_o = ls_drive_i | ls_gnd_i | ls_open_i;
    assign ign_ovc_o = src & ign_gnd_i;
    assign ign_below_lvt_o = (~src | ign_gnd_i) & ~ign_bat_i;
    assign ign_open_o = src & ign_open_i;
    assign ign_scb_o = ign_bat_i;
endmodule
`default_nettype wire

// ==== verif/power_stage_fault_diag_bench.sv ====
// Purpose: Self-checking bench
// Assumes: Off-diagnosis mask shortened to 400 cycles
// Notes:   Results queued by the driver, checked on response
`timescale 1ns/100ps
`default_nettype none
`include "power_stage_fault_diag_defs.vh"
module power_stage_fault_diag_bench;
    localparam int MC = 400;
    logic clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, sh = 0, gn = 0, op = 0, rv;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hf, par = 0, gs = 0, io = 0, sc = 0;
    wire awready, wready, bvalid, arready, rvalid, lcp;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] ovc, blo, bhi, drv;
    wire [3:0] overcurrent_limit, ilvt, iopen, iscb, ihigh, ioe;
    logic [65:0] rq[$];
    logic [1:0] bq[$];
    logic [65:0] e;
    int n_fail = 0, checks = 0;
    always #12.5 clk = ~clk;
    power_stage_fault_diag #(.MASK_CYC(MC)) dut_u (.ref_clk_i(clk), .rst_n_i(rst_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ls_ovc_i(ovc),
        .ls_below_low_i(blo), .ls_below_high_i(bhi), .ls_drive_o(drv), .lc_pull_en_o(lcp),
        .ign_par_i(par), .ign_ovc_i(overcurrent_limit), .ign_below_lvt_i(ilvt), .ign_open_i(iopen),
        .ign_scb_i(iscb), .ign_high_o(ihigh), .ign_oe_o(ioe));
    load_model load_u (.ls_drive_i(drv), .ls_short_i(sh), .ls_gnd_i(gn), .ls_open_i(op),
        .ign_high_i(ihigh), .ign_oe_i(ioe), .ign_gnd_i(gs), .ign_open_i(io), .ign_bat_i(sc),
        .ls_ovc_o(ovc), .ls_below_low_o(blo), .ls_below_high_o(bhi), .ign_ovc_o(overcurrent_limit),
        .ign_below_lvt_o(ilvt), .ign_open_o(iopen), .ign_scb_o(iscb));
    task automatic chk(input logic ok);
        checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t: mismatch", $time);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
        bq.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge clk); while (!awready);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge clk); while (!wready);
                wvalid <= 1'b0;
            end
        join
        while (!bvalid) @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] m = 32'hffffffff, input logic [1:0] r = 2'b00);
        rq.push_back({r, m, d & m});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
    endtask
    // ------
    // Result watcher: oldest note against each response
    // ------
    always @(posedge clk) begin
        if (rvalid && rready) begin
            e = rq.pop_front();
            chk((rdata & e[63:32]) === e[31:0] && rresp === e[65:64]);
        end
        if (bvalid && bready) chk(bresp === bq.pop_front());
    end
    initial begin
        w(60000);
        $display("ERROR %0t: timeout", $time);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(32'hc23293ff));
        w(4);
        rst_n <= 1'b1;
        rd(`ADDR_DIAG_LS, 32'hffff);
        rd(`ADDR_DIAG_IGN, 32'hff);
        rd(`ADDR_CONFIG_TWO, 32'h08);
        rd(8'h18, 32'h0, 32'hffffffff, `RESP_DECERR);
        wr(`ADDR_DIAG_LS, 32'h0, `RESP_DECERR);
        rv = 8'($urandom);
        wr(`ADDR_LS_CMD, {24'h0, rv});
        rd(`ADDR_LS_CMD, {24'h0, rv}, 32'hff);
        sh <= 8'h01;
        wr(`ADDR_LS_CMD, 32'h01);
        w(70);
        rd(`ADDR_STATUS, 32'h1, 32'h1);
        w(130);
        rd(`ADDR_STATUS, 32'h0, 32'h1);
        sh <= 8'h00;
        rd(`ADDR_DIAG_LS, 32'h2, 32'h3);
        w(4);
        rd(`ADDR_STATUS, 32'h1, 32'h1);
        rd(`ADDR_DIAG_LS, 32'hffff);
        wr(`ADDR_CONFIG_TWO, 32'h18);
        w(2);
        chk(lcp === 1'b0);
        wr(`ADDR_LS_CMD, 32'h87);
        w(4);
        wr(`ADDR_LS_CMD, 32'h01);
        {gn, op} <= 16'h8204;
        w(MC + 1800);
        rd(`ADDR_DIAG_LS, 32'hffff);
        w(300);
        {gn, op} <= 16'h8006;
        w(2100);
        rd(`ADDR_DIAG_LS, 32'hffd3);
        {gn, op} <= 16'h0000;
        par <= 4'h1;
        wr(`ADDR_IGN_CMD, 32'h3);
        w(4);
        chk(ihigh === 4'h1);
        wr(`ADDR_CONFIG_TWO, 32'h1a);
        rd(`ADDR_STATUS, 32'h0, 32'hf00);
        wr(`ADDR_CONFIG_TWO, 32'h19);
        rd(`ADDR_STATUS, 32'h100, 32'hf00);
        wr(`ADDR_CONFIG_TWO, 32'h18);
        sc <= 4'h4;
        w(3100);
        rd(`ADDR_STATUS, 32'hb00, 32'hf00);
        rd(`ADDR_DIAG_IGN, 32'hef);
        sc <= 4'h0;
        w(4);
        rd(`ADDR_STATUS, 32'hf00, 32'hf00);
        io <= 4'h1;
        w(3100);
        rd(`ADDR_STATUS, 32'hf01, 32'hfff);
        rd(`ADDR_DIAG_IGN, 32'hfd);
        sc <= 4'h1;
        w(3100);
        rd(`ADDR_DIAG_IGN, 32'hfe);
        io <= 4'h0;
        wr(`ADDR_CONFIG_TWO, 32'h10);
        w(3100);
        sc <= 4'h0;
        w(100);
        rd(`ADDR_STATUS, 32'h0, 32'h100);
        w(3000);
        rd(`ADDR_STATUS, 32'h100, 32'h100);
        rd(`ADDR_DIAG_IGN, 32'hff);
        wr(`ADDR_CONFIG_TWO, 32'h18);
        par <= 4'h3;
        gs <= 4'h2;
        w(3100);
        rd(`ADDR_STATUS, 32'h0, 32'h200);
        gs <= 4'h0;
        rd(`ADDR_DIAG_IGN, 32'hf3);
        w(4);
        rd(`ADDR_STATUS, 32'h200, 32'h200);
        wr(`ADDR_CONFIG_TWO, 32'h1c);
        gs <= 4'h1;
        w(3100);
        rd(`ADDR_STATUS, 32'h0, 32'h100);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ==== verif/power_stage_fault_diag_monitor.sv ====
// Purpose: Port checks
// Assumes: Fixed filter lengths of 160 and 3000 cycles
// Notes:   Bound into every instance
`timescale 1ns/100ps
`default_nettype none
module power_stage_fault_diag_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [7:0] ls_ovc_i,
    input wire logic [7:0] ls_drive_o,
    input wire logic [3:0] ign_par_i,
    input wire logic [3:0] ign_scb_i,
    input wire logic [3:0] ign_high_o,
    input wire logic [3:0] ign_oe_o
);
    logic [15:0] ovc_cnt;
    logic [15:0] scb_cnt;
    logic [15:0] pin_d;
    wire [3:0] pin_win = pin_d[7:4] | pin_d[11:8] | pin_d[15:12];
    wire rearm = (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 8'h10)
        || (s_axi_awvalid_i && s_axi_awready_o && s_axi_awaddr_i == 8'h04);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ------
    // Watch counters, lane 0 only to keep them cheap
    // ------
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || !(ls_drive_o[0] && ls_ovc_i[0])) begin
            ovc_cnt <= 16'h0000;
        end else begin
            ovc_cnt <= ovc_cnt + 16'h0001;
        end
        if (!rst_n_i || !ign_scb_i[0] || rearm) begin
            scb_cnt <= 16'h0000;
        end else if (scb_cnt != 16'h0fa0) begin
            scb_cnt <= scb_cnt + 16'h0001;
        end
        if (!rst_n_i) begin
            pin_d <= 16'h0000;
        end else begin
            pin_d <= {pin_d[11:0], ign_par_i};
        end
    end
    rst_float_a: assert property (disable iff (1'b0) !rst_n_i |=> ign_oe_o == 4'h0)
        else $error("ignition driven after reset edge");
    ign_pin_a: assert property ((ign_high_o & ~pin_win) == 4'h0)
        else $error("ignition high without its pin");
    ovc_trip_a: assert property (ovc_cnt < 16'h00aa)
        else $error("overcurrent not switched off in time");
    scb_float_a: assert property (scb_cnt > 16'h0bc2 |-> !ign_oe_o[0])
        else $error("battery short left output driven");
    bresp_hold_a: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
        else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read not answered next cycle");
    write_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o
        && s_axi_wvalid_i && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
        else $error("write not answered");
    unmapped_rd_a: assert property (s_axi_arvalid_i && s_axi_arready_o
        && s_axi_araddr_i > 8'h14 |=> s_axi_rresp_o == 2'b11 && s_axi_rdata_o == 32'h0)
        else $error("unmapped read not refused");
    cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'b11);
    cover property ($fell(ls_drive_o[0]));
    cover property (scb_cnt > 16'h0bc2);
endmodule
bind power_stage_fault_diag power_stage_fault_diag_monitor mon_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i), .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bresp_o(s_axi_bresp_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_araddr_i(s_axi_araddr_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .ls_ovc_i(ls_ovc_i),
    .ls_drive_o(ls_drive_o), .ign_par_i(ign_par_i), .ign_scb_i(ign_scb_i),
    .ign_high_o(ign_high_o), .ign_oe_o(ign_oe_o));
`default_nettype wire
